/* shared/upload_status_regs.vh */
`ifndef UPLOAD_STATUS_REGS_VH
`define UPLOAD_STATUS_REGS_VH
// status word field positions
`define LEN_MSB 12
`define ERR_SUM_BIT 14
`define DONE_BIT 15
`define OVERRUN_BIT 16
`define SHORT_BIT 17
`define MISALIGN_BIT 18
`define CRCFAIL_BIT 19
`define TOOLONG_BIT 20
`define TRAIL_BIT 23
`define EXHAUST_BIT 24
`define L3FAIL_BIT 25
`define STREAMFAIL_BIT 26
`define DGRAMFAIL_BIT 27
`define INLINE_BIT 28
`define L3VALID_BIT 29
`define STREAMVALID_BIT 30
`define DGRAMVALID_BIT 31
// descriptor layout and sizes
`define STATUS_DW_OFFSET 32'h0000_0004
`define INLINE_BUF_OFFSET 32'h0000_0008
`define FRAG_OFFSET 32'h0000_0008
`define INLINE_BUF_LEN 13'h05f8
`define SHORT_FRAME_LEN 13'h003c
`define FRAG_LEN_MSB 12
`define FRAG_LAST_BIT 31
// register offsets on the bus
`define REG_STATUS 8'h00
`define REG_CTRL 8'h04
`define REG_MAXLEN 8'h08
`define REG_DESC 8'h0c
`define REG_COUNT 8'h10
`define MAXLEN_RESET 13'h05f2
`endif

/* hdl/rx_upload_packet_status.v */
`timescale 1ns/1ns
`include "upload_status_regs.vh"
module rx_upload_packet_status
(
  input wire ref_clk,
  input wire reset,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // receive byte stream from the fifo side
  input wire rxValid,
  input wire [7:0] rxByte,
  input wire rxLast,
  output wire rxReady,
  input wire fifoOverrun,
  input wire frameCrcBad,
  input wire trailingBits,
  input wire ipHeaderSeen,
  input wire ipSumBad,
  input wire tcpHeaderSeen,
  input wire tcpSumBad,
  input wire udpHeaderSeen,
  input wire udpSumBad,
  input wire datagramFragmented,
  // simple memory master: one word or byte per request
  output reg memReq,
  output reg memWrite,
  output reg memByte,
  output reg [31:0] memAddr,
  output reg [31:0] memWdata,
  input wire memAck,
  input wire [31:0] memRdata,
  output wire uploadBusy
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RDSTAT = 3'h1;
  localparam ST_RDADDR = 3'h2;
  localparam ST_RDLEN = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_DRAIN = 3'h5;
  localparam ST_WBACK = 3'h6;

  reg [2:0] state_r;
  reg [31:0] descAddr_r;
  reg [31:0] fragPtr_r;
  reg [31:0] bufAddr_r;
  reg [12:0] bufLeft_r;
  reg lastFrag_r;
  reg [12:0] count_r;
  reg [12:0] frameLen_r;
  reg exhaust_r;
  reg overrun_r;
  reg crcBad_r;
  reg trail_r;
  reg start_r;
  reg enable_r;
  reg [12:0] maxLen_r;
  reg [31:0] status_r;
  reg [15:0] doneCount_r;
  reg dphWrite_r;
  reg dphValid_r;
  reg [7:0] dphAddr_r;

  wire [31:0] statusWord;
  wire err;
  wire shortF;
  wire longF;
  wire addrPhase;
  wire byteTaken;
  wire misalign;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign uploadBusy = (state_r != ST_IDLE);
  // stream advances only when a byte write is acknowledged, or while draining; it stalls in every other state
  assign rxReady = ((state_r == ST_DATA) && memAck) || (state_r == ST_DRAIN);
  assign byteTaken = rxValid && rxReady;
  assign addrPhase = hsel && hready && htrans[1];

  // error flags and the assembled status word
  assign shortF = (frameLen_r < `SHORT_FRAME_LEN);
  assign longF = (frameLen_r > maxLen_r);
  assign misalign = crcBad_r && trail_r;
  assign err = overrun_r | shortF | misalign | crcBad_r | longF;
  assign statusWord = {
    udpHeaderSeen & ~datagramFragmented,
    tcpHeaderSeen & ~datagramFragmented,
    ipHeaderSeen,
    1'b0,
    udpSumBad & udpHeaderSeen,
    tcpSumBad & tcpHeaderSeen,
    ipSumBad & ipHeaderSeen,
    exhaust_r,
    trail_r,
    2'b00,
    longF,
    crcBad_r,
    misalign,
    shortF,
    overrun_r,
    1'b1,
    err,
    1'b0,
    count_r};

  // ahb-lite address phase capture and register writes
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      dphValid_r <= 1'b0;
      dphWrite_r <= 1'b0;
      dphAddr_r <= 8'h00;
      enable_r <= 1'b0;
      maxLen_r <= `MAXLEN_RESET;
      descAddr_r <= 32'h0000_0000;
      start_r <= 1'b0;
    end
    else
    begin
      dphValid_r <= addrPhase;
      dphWrite_r <= hwrite;
      dphAddr_r <= haddr[7:0];
      start_r <= 1'b0;
      if (dphValid_r && dphWrite_r)
      begin
        case (dphAddr_r)
          `REG_CTRL:
          begin
            enable_r <= hwdata[0];
          end
          `REG_MAXLEN:
          begin
            maxLen_r <= hwdata[12:0];
          end
          `REG_DESC:
          begin
            descAddr_r <= {hwdata[31:3], 3'h0};
            start_r <= (hwdata[31:3] != 29'h0);
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // read data for the data phase
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addrPhase && !hwrite)
    begin
      case (haddr[7:0])
        `REG_STATUS: hrdata <= status_r;
        `REG_CTRL: hrdata <= {28'h0, state_r, enable_r};
        `REG_MAXLEN: hrdata <= {19'h0, maxLen_r};
        `REG_DESC: hrdata <= descAddr_r;
        `REG_COUNT: hrdata <= {16'h0, doneCount_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // upload engine
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memByte <= 1'b0;
      memAddr <= 32'h0000_0000;
      memWdata <= 32'h0000_0000;
      fragPtr_r <= 32'h0000_0000;
      bufAddr_r <= 32'h0000_0000;
      bufLeft_r <= 13'h0000;
      lastFrag_r <= 1'b0;
      count_r <= 13'h0000;
      frameLen_r <= 13'h0000;
      exhaust_r <= 1'b0;
      overrun_r <= 1'b0;
      crcBad_r <= 1'b0;
      trail_r <= 1'b0;
      status_r <= 32'h0000_0000;
      doneCount_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_r && enable_r)
          begin
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memByte <= 1'b0;
            memAddr <= descAddr_r + `STATUS_DW_OFFSET;
            state_r <= ST_RDSTAT;
          end
        end
        ST_RDSTAT:
        begin
          if (memAck)
          begin
            // inline and done bits come from the same word; done is tested first and ends the upload before inline is looked at
            count_r <= 13'h0000;
            frameLen_r <= 13'h0000;
            exhaust_r <= 1'b0;
            if (memRdata[`DONE_BIT])
            begin
              memReq <= 1'b0;
              state_r <= ST_IDLE;
            end
            else if (memRdata[`INLINE_BIT])
            begin
              bufAddr_r <= descAddr_r + `INLINE_BUF_OFFSET;
              bufLeft_r <= `INLINE_BUF_LEN;
              lastFrag_r <= 1'b1;
              memReq <= 1'b1;
              memWrite <= 1'b1;
              memByte <= 1'b1;
              memAddr <= descAddr_r + `INLINE_BUF_OFFSET;
              state_r <= ST_DATA;
            end
            else
            begin
              fragPtr_r <= descAddr_r + `FRAG_OFFSET;
              memAddr <= descAddr_r + `FRAG_OFFSET;
              state_r <= ST_RDADDR;
            end
          end
        end
        ST_RDADDR:
        begin
          if (memAck)
          begin
            bufAddr_r <= memRdata;
            memAddr <= fragPtr_r + `STATUS_DW_OFFSET;
            state_r <= ST_RDLEN;
          end
        end
        ST_RDLEN:
        begin
          if (memAck)
          begin
            bufLeft_r <= memRdata[`FRAG_LEN_MSB:0];
            memReq <= (memRdata[`FRAG_LEN_MSB:0] != 13'h0000); // empty fragment: no byte request
            lastFrag_r <= memRdata[`FRAG_LAST_BIT];
            fragPtr_r <= fragPtr_r + `FRAG_OFFSET;
            memWrite <= 1'b1;
            memByte <= 1'b1;
            memAddr <= bufAddr_r;
            state_r <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (bufLeft_r == 13'h0000)
          begin
            if (lastFrag_r)
            begin
              exhaust_r <= 1'b1;
              state_r <= ST_DRAIN;
            end
            else
            begin
              memWrite <= 1'b0;
              memByte <= 1'b0;
              memAddr <= fragPtr_r;
              memReq <= 1'b1;
              state_r <= ST_RDADDR;
            end
          end
          else if (byteTaken)
          begin
            count_r <= count_r + 13'h0001;
            frameLen_r <= frameLen_r + 13'h0001;
            bufLeft_r <= bufLeft_r - 13'h0001;
            bufAddr_r <= bufAddr_r + 32'h0000_0001;
            memAddr <= bufAddr_r + 32'h0000_0001;
            memReq <= (bufLeft_r != 13'h0001); // no stray byte write past the buffer end
            if (rxLast)
            begin
              overrun_r <= fifoOverrun;
              crcBad_r <= frameCrcBad;
              trail_r <= trailingBits;
              memWrite <= 1'b0;
              memReq <= 1'b0;
              state_r <= ST_WBACK;
            end
          end
          memWdata <= {24'h0, rxByte};
        end
        ST_DRAIN:
        begin
          // remaining bytes counted for length checks but dropped
          if (byteTaken)
          begin
            frameLen_r <= frameLen_r + 13'h0001;
            if (rxLast)
            begin
              overrun_r <= fifoOverrun;
              crcBad_r <= frameCrcBad;
              trail_r <= trailingBits;
              state_r <= ST_WBACK;
            end
          end
        end
        ST_WBACK:
        begin
          if (!memReq)
          begin
            memReq <= 1'b1;
            memWrite <= 1'b1;
            memByte <= 1'b0;
            memAddr <= descAddr_r + `STATUS_DW_OFFSET;
            memWdata <= statusWord;
            status_r <= statusWord;
          end
          else if (memAck)
          begin
            memReq <= 1'b0;
            doneCount_r <= doneCount_r + 16'h0001;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // rx_upload_packet_status

/* verif/rx_upload_monitor.sv */
`timescale 1ns/1ns
module rx_upload_monitor (
  input wire ref_clk,
  input wire reset,
  input wire rxReady,
  input wire memReq,
  input wire memWrite,
  input wire memByte,
  input wire [31:0] memAddr,
  input wire [31:0] memWdata,
  input wire memAck,
  input wire ipHeaderSeen,
  input wire ipSumBad,
  input wire datagramFragmented
);
  // status word write-back being accepted
  wire stW = memReq && memWrite && !memByte && memAck;
  wire [31:0] w = memWdata;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_req_held: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("request dropped");
  a_byte_ready: assert property (memAck && memWrite && memByte |-> rxReady)
    else $error("byte taken without ready");
  a_status_dw: assert property (stW |-> memAddr[2:0] == 3'h4)
    else $error("status not at second word");
  a_done_bit: assert property (stW |-> w[15] && !w[13] && w[22:21] == 2'h0)
    else $error("done or zero bits wrong");
  a_err_sum: assert property (stW |-> w[14] == |w[20:16])
    else $error("error summary wrong");
  a_align_err: assert property (stW |-> w[18] == (w[19] && w[23]))
    else $error("alignment flag wrong");
  a_l3_sum: assert property (stW |-> w[29] == ipHeaderSeen && w[25] == (ipHeaderSeen && ipSumBad))
    else $error("ip checksum flags wrong");
  a_frag_l4: assert property (stW && datagramFragmented |-> w[31:30] == 2'h0)
    else $error("l4 flag on fragment");
endmodule // rx_upload_monitor

bind rx_upload_packet_status rx_upload_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .rxReady(rxReady),
  .memReq(memReq), .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
  .memAck(memAck), .ipHeaderSeen(ipHeaderSeen), .ipSumBad(ipSumBad), .datagramFragmented(datagramFragmented));

/* verif/host_mem_model.sv */
`timescale 1ns/1ns
module host_mem_model (
  input wire ref_clk,
  input wire reset,
  input wire memReq,
  input wire memWrite,
  input wire memByte,
  input wire [31:0] memAddr,
  input wire [31:0] memWdata,
  output reg memAck = 1'b0,
  output reg [31:0] memRdata = 32'h0
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] st, fa;
  int nB = 0, nS = 0, wt = 0;
  // answer each request after 0 to 2 idle cycles; read data scrambled when idle
  always @(posedge ref_clk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (reset)
      wt <= 0;
    else if (memReq && !memAck)
    begin
      if (wt > 0)
        wt <= wt - 1;
      else
      begin
        memAck <= 1'b1;
        wt <= $urandom % 3;
        if (!memWrite)
          memRdata <= mem.exists(memAddr) ? mem[memAddr] : 32'h0;
        else if (memByte)
        begin
          if (nB == 0)
            fa <= memAddr;
          nB <= nB + 1;
        end
        else
        begin
          st <= memWdata;
          nS <= nS + 1;
        end
      end
    end
  end
endmodule // host_mem_model

/* verif/tb_rx_upload_packet_status.sv */
`timescale 1ns/1ns
`include "upload_status_regs.vh"
module tb_rx_upload_packet_status;
  logic ref_clk, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, rxValid = 1'b0, rxLast = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] rxByte = 8'h0;
  logic [9:0] fl = 10'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire [31:0] hrdata, memAddr, memWdata, memRdata;
  wire hreadyout, hresp, rxReady, memReq, memWrite, memByte, memAck, uploadBusy;
  int fails = 0, checks = 0, mx, i;

  rx_upload_packet_status u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rxValid(rxValid), .rxByte(rxByte), .rxLast(rxLast), .rxReady(rxReady),
    .fifoOverrun(fl[0]), .frameCrcBad(fl[1]), .trailingBits(fl[2]), .ipHeaderSeen(fl[3]), .ipSumBad(fl[4]),
    .tcpHeaderSeen(fl[5]), .tcpSumBad(fl[6]), .udpHeaderSeen(fl[7]), .udpSumBad(fl[8]),
    .datagramFragmented(fl[9]), .memReq(memReq), .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .uploadBusy(uploadBusy));
  host_mem_model u_mem (.ref_clk(ref_clk), .reset(reset), .memReq(memReq), .memWrite(memWrite),
    .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // bounded wait: 0 bus ready, 1 byte taken, 2 engine idle
  task waitOn(input int w);
    int k;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (k < 99 && (w == 0 ? hreadyout !== 1'b1 : w == 1 ? rxReady !== 1'b1 : uploadBusy !== 1'b0));
    if (k >= 99)
    begin
      fails++;
      end_sim;
    end
  endtask

  // single word transfer: address phase, then data phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitOn(0);
    htrans <= 2'h0;
    hwdata <= d;
    waitOn(0);
    q = hrdata;
  endtask

  // status word the device should write back
  function automatic logic [31:0] expSt(input int len, input int cap, input logic [9:0] f);
    logic [31:0] e;
    int up;
    up = len < cap ? len : cap;
    e = 32'h0;
    e[12:0] = up[12:0];
    e[24] = len > cap;
    e[16] = f[0];
    e[17] = len < 60;
    e[18] = f[1] && f[2];
    e[19] = f[1];
    e[20] = len > mx;
    e[23] = f[2];
    e[14] = |e[20:16];
    e[15] = 1'b1;
    e[29] = f[3];
    e[25] = f[3] && f[4];
    e[30] = f[5] && !f[9];
    e[31] = f[7] && !f[9];
    e[26] = e[30] && f[6];
    e[27] = e[31] && f[8];
    return e;
  endfunction

  // one upload: descriptor set up, frame streamed, write-back checked
  task upload(input logic inl, input int len, input int cap);
    logic [31:0] d, e;
    logic [9:0] v;
    d = inl ? 32'h1000 : 32'h2000;
    v = $urandom;
    v[6] = v[6] & !v[9];
    v[8] = v[8] & !v[9];
    fl <= v;
    u_mem.nB = 0;
    u_mem.mem[d + 4] = {3'h0, inl, 28'h0};
    u_mem.mem[d + 8] = 32'h8000;
    u_mem.mem[d + 12] = cap / 2;
    u_mem.mem[d + 16] = 32'h9001;
    u_mem.mem[d + 20] = cap - cap / 2 + 32'h8000_0000;
    ahb(1'b1, `REG_DESC, d, r);
    for (int k = 0; k < len; k++)
    begin
      rxValid <= 1'b1;
      rxByte <= $urandom;
      rxLast <= k == len - 1;
      waitOn(1);
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    waitOn(2);
    e = expSt(len, cap, v);
    chk(u_mem.st & 32'hefff_ffff, e);
    chk(u_mem.nB, len < cap ? len : cap);
    chk(u_mem.fa, inl ? d + 8 : 32'h8000);
    ahb(1'b0, `REG_STATUS, 32'h0, r);
    chk(r & 32'hefff_ffff, e);
  endtask

  initial
  begin
    r = $urandom(32'hbfaea70e);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    ahb(1'b0, `REG_MAXLEN, 32'h0, r);
    chk(r, {19'h0, `MAXLEN_RESET});
    ahb(1'b0, 32'h40, 32'h0, r);
    chk(r, 32'h0);
    mx = 100;
    ahb(1'b1, `REG_MAXLEN, mx, r);
    ahb(1'b1, `REG_CTRL, 32'h1, r);
    // descriptor already complete: no bytes, no write-back
    u_mem.mem[32'h3004] = 32'h8000;
    ahb(1'b1, `REG_DESC, 32'h3000, r);
    repeat (3) @(posedge ref_clk);
    waitOn(2);
    chk(u_mem.nS, 32'h0);
    chk(u_mem.nB, 32'h0);
    upload(1'b1, 1530, 1528);
    for (i = 0; i < 8; i++)
      upload(i[0], 40 + $urandom % 100, i[0] ? 1528 : 30 + $urandom % 120);
    end_sim;
  end
endmodule // tb_rx_upload_packet_status
